// >>> lcc_cluster.sv
// Logic cluster of ten cells with its cluster-wide control path,
// configured and observed over APB.
// Assumes control and data lines arrive from outside the pclk domain and
// are resynchronised here; cluster clocks are sampled as levels.
//
// Overview of operation
// - Ten cells share controls, chains, routing
// - Two cluster clocks and two enables
// - Each clock fixed to its own enable
// - Rising and falling edges use both lines
// - Clear lines also give preset and load
// - Sync clear and load hit every register
// - Counter uses two three-input lookups
// - Load selector, clear forces input low
// - Sync clear or load beats cascade
// - Clear wins over simultaneous load
// - Arithmetic shows registered and raw results
// - Packing in normal mode, not with carry
// - First cell feeds register back inside
// - Inputs one, two: enable, feedback, except cell 1
// - Hardware asynchronous clear on every register; here only LCC_ASYNC_CLEAR cells clear
// - Emulated preset-and-load comes up unknown
// - Enabled chip reset clears all non-preset registers
// - Chip reset overrides every other control
// - Preset registers go high under reset
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lcc_params.svh"

module lcc_cluster
    import lcc_pkg::*;
#(
    parameter int NCELL = `LCC_NUM_CELLS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Cluster-wide controls from user logic
    input wire logic cluster_clock_one,
    input wire logic cluster_clock_two,
    input wire logic cluster_clock_enable_one,
    input wire logic cluster_clock_enable_two,
    input wire logic cluster_clear_one,
    input wire logic cluster_clear_two,
    input wire logic cluster_sync_clear,
    input wire logic cluster_sync_load,
    input wire logic chip_reset_n,
    input wire logic cluster_carry_in,
    input wire logic cluster_cascade_in,
    // Cell data inputs, four per cell, cell 0 in the low nibble
    input wire logic [NCELL*4-1:0] cell_data,
    // Cell results
    output logic [NCELL-1:0] cell_q,
    output logic [NCELL-1:0] cell_lut_out,
    output logic cluster_carry_out,
    output logic cluster_cascade_out
);

    // Three- or four-input lookup, used by normal, arithmetic and counter modes
    function automatic logic lut_pick(input logic [15:0] mask, input logic [3:0] idx);
        lut_pick = mask[idx];
    endfunction

    lcc_ctl_s ctl_raw;
    lcc_ctl_s ctl_m_r;
    lcc_ctl_s ctl_r;
    logic [NCELL*4-1:0] dat_m_r;
    logic [NCELL*4-1:0] dat_r;
    logic clk_one_d_r;
    logic clk_two_d_r;
    logic [31:0] ctrl_r;
    lcc_cfg_s cfg_r [NCELL];
    logic over_r;
    logic [NCELL-1:0] unk_r;
    logic [NCELL-1:0] q_r;
    logic [NCELL-1:0] lut_r;
    logic carry_out_r;
    logic casc_out_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;

    // Combinational cell results
    logic [NCELL-1:0] reg_in;
    logic [NCELL-1:0] capture;
    logic [NCELL-1:0] lut_now;
    logic [NCELL-1:0] aload_val;
    logic carry_last;
    logic casc_last;
    logic edge_one;
    logic edge_two;
    logic chip_rst;
    logic [7:0] ctl_act;
    logic acc;
    logic wr_acc;
    logic rd_acc;
    logic [31:0] rd_mux;
    logic rd_err;

    assign ctl_raw = '{clk_one: cluster_clock_one, clk_two: cluster_clock_two,
                       ce_one: cluster_clock_enable_one, ce_two: cluster_clock_enable_two,
                       clr_one: cluster_clear_one, clr_two: cluster_clear_two,
                       sclr: cluster_sync_clear, sload: cluster_sync_load,
                       rst_n: chip_reset_n, carry_in: cluster_carry_in,
                       casc_in: cluster_cascade_in};

    // Two-stage synchroniser; chip reset idles high so it is inactive at release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_m_r <= '{rst_n: 1'b1, default: 1'b0};
            ctl_r <= '{rst_n: 1'b1, default: 1'b0};
            dat_m_r <= '0;
            dat_r <= '0;
        end else begin
            ctl_m_r <= ctl_raw;
            ctl_r <= ctl_m_r;
            dat_m_r <= cell_data;
            dat_r <= dat_m_r;
        end
    end

    // Delayed copies of the synchronised clock lines for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_one_d_r <= 1'b0;
            clk_two_d_r <= 1'b0;
        end else begin
            clk_one_d_r <= ctl_r.clk_one;
            clk_two_d_r <= ctl_r.clk_two;
        end
    end

    // Each cluster line has one edge polarity, so mixed edges need both lines
    always_comb begin
        edge_one = ctrl_r[`LCC_CTRL_EDGE_ONE] ? (clk_one_d_r & ~ctl_r.clk_one)
                                              : (~clk_one_d_r & ctl_r.clk_one);
        edge_two = ctrl_r[`LCC_CTRL_EDGE_TWO] ? (clk_two_d_r & ~ctl_r.clk_two)
                                              : (~clk_two_d_r & ctl_r.clk_two);
    end

    // Chip reset acts only when software enabled the option
    assign chip_rst = ctrl_r[`LCC_CTRL_RST_EN] & ~ctl_r.rst_n;

    // Cell datapath: lookups, chains, selectors, sync clear and load
    always_comb begin
        logic carry;
        logic casc;
        logic d1;
        logic d2;
        logic d3;
        logic d4;
        logic en_ok;
        logic lo;
        logic co;
        logic din;
        logic [3:0] idx;
        lcc_cfg_s c;
        carry = ctl_r.carry_in;
        casc = ctl_r.casc_in;
        d1 = 1'b0;
        d2 = 1'b0;
        d3 = 1'b0;
        d4 = 1'b0;
        en_ok = 1'b1;
        lo = 1'b0;
        co = 1'b0;
        din = 1'b0;
        idx = 4'h0;
        c = '0;
        reg_in = '0;
        capture = '0;
        lut_now = '0;
        aload_val = '0;
        for (int i = 0; i < NCELL; i++) begin
            c = cfg_r[i];
            d1 = dat_r[i*4];
            d2 = dat_r[i*4+1];
            d3 = dat_r[i*4+2];
            d4 = dat_r[i*4+3];
            en_ok = 1'b1;
            // The second cell has no special input roles
            if (i != 1) begin
                if (c.role1 == LCC_ROLE_FEEDBACK) d1 = q_r[i];
                if (c.role2 == LCC_ROLE_FEEDBACK) d2 = q_r[i];
                if (c.role1 == LCC_ROLE_COUNT_EN) en_ok = d1;
                if (c.role2 == LCC_ROLE_COUNT_EN) en_ok = en_ok & d2;
            end
            // Register feedback selector on the first cell
            if (i == 0 && c.fb_sel) d3 = q_r[i];
            unique case (c.mode)
                LCC_MODE_NORMAL: begin
                    idx = {d4, c.use_carry ? carry : d3, d2, d1};
                    lo = lut_pick(c.mask, idx);
                    co = 1'b0;
                end
                LCC_MODE_ARITH, LCC_MODE_COUNTER: begin
                    // Low half gives the sum or next count, high half the carry
                    idx = {1'b0, carry, d2, d1};
                    lo = lut_pick(c.mask, idx);
                    co = lut_pick(c.mask, idx | 4'h8);
                end
                default: begin
                    idx = 4'h0;
                    lo = 1'b0;
                    co = 1'b0;
                end
            endcase
            if (c.use_casc) lo = lo & casc;
            lut_now[i] = lo;
            // Packing feeds the register straight from the fourth input
            if (c.mode == LCC_MODE_NORMAL && c.pack && !c.use_carry) begin
                din = d4;
            end else begin
                din = lo;
            end
            // Load selector then clearing gate; both override the cascade term
            din = ctl_r.sload ? d4 : din;
            din = din & ~ctl_r.sclr;
            reg_in[i] = din;
            aload_val[i] = d4;
            capture[i] = (c.clk_sel ? (edge_two & ctl_r.ce_two)
                                    : (edge_one & ctl_r.ce_one)) & en_ok;
            casc = lo;
            carry = co;
        end
        carry_last = carry;
        casc_last = casc;
    end

    // Cell registers: chip reset first, then cluster clear lines, then clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= '0;
        end else begin
            for (int i = 0; i < NCELL; i++) begin
                if (chip_rst) begin
                    q_r[i] <= (cfg_r[i].amode == LCC_ASYNC_PRESET);
                end else if (cfg_r[i].amode != LCC_ASYNC_NONE &&
                             (cfg_r[i].aline ? ctl_r.clr_two : ctl_r.clr_one)) begin
                    unique case (cfg_r[i].amode)
                        LCC_ASYNC_CLEAR: q_r[i] <= 1'b0;
                        LCC_ASYNC_PRESET: q_r[i] <= 1'b1;
                        LCC_ASYNC_LOAD: q_r[i] <= aload_val[i];
                        default: q_r[i] <= q_r[i];
                    endcase
                end else if (capture[i]) begin
                    q_r[i] <= reg_in[i];
                end
            end
        end
    end

    // Emulated preset-and-load registers are flagged unknown until the next clock capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unk_r <= '0;
        end else begin
            for (int i = 0; i < NCELL; i++) begin
                if (chip_rst && cfg_r[i].amode == LCC_ASYNC_LOAD) begin
                    unk_r[i] <= 1'b1;
                end else if (capture[i]) begin
                    unk_r[i] <= 1'b0;
                end
            end
        end
    end

    // Registered view of the unregistered results and chain outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lut_r <= '0;
            carry_out_r <= 1'b0;
            casc_out_r <= 1'b0;
        end else begin
            lut_r <= lut_now;
            carry_out_r <= carry_last;
            casc_out_r <= casc_last;
        end
    end

    // Count active cluster-wide controls; overload is a user fault, only flagged
    assign ctl_act = {ctl_r.clk_one, ctl_r.clk_two, ctl_r.ce_one, ctl_r.ce_two,
                      ctl_r.clr_one, ctl_r.clr_two, ctl_r.sclr, ctl_r.sload};

    // APB access decode
    assign acc = psel & penable & ~pready_r;
    assign wr_acc = acc & pwrite;
    assign rd_acc = acc & ~pwrite;

    // Overload sticky bit; a new overload wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            over_r <= 1'b0;
        end else if ($countones(ctl_act) > `LCC_CTL_LIMIT) begin
            over_r <= 1'b1;
        end else if (wr_acc && paddr == `LCC_OFS_STATUS && pwdata[`LCC_STAT_OVER]) begin
            over_r <= 1'b0;
        end
    end

    // Control and configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `LCC_CTRL_RESET;
            for (int i = 0; i < NCELL; i++) cfg_r[i] <= `LCC_CFG_RESET;
        end else if (wr_acc) begin
            if (paddr == `LCC_OFS_CTRL) ctrl_r <= pwdata & 32'h0000_0007;
            for (int i = 0; i < NCELL; i++) begin
                if (paddr == `LCC_OFS_CFG_BASE + 12'(i*4)) begin
                    cfg_r[i] <= pwdata & 32'h3fff_ffff;
                end
            end
        end
    end

    // Read mux and unmapped-address detection
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b1;
        if (paddr == `LCC_OFS_CTRL) begin
            rd_mux = ctrl_r;
            rd_err = 1'b0;
        end else if (paddr == `LCC_OFS_STATUS) begin
            rd_mux[`LCC_STAT_OVER] = over_r;
            rd_mux[`LCC_STAT_UNK_LSB +: NCELL] = unk_r;
            rd_err = 1'b0;
        end else if (paddr == `LCC_OFS_CELLS) begin
            rd_mux[`LCC_CELLS_Q_LSB +: NCELL] = q_r;
            rd_mux[`LCC_CELLS_LUT_LSB +: NCELL] = lut_r;
            rd_err = 1'b0;
        end
        for (int i = 0; i < NCELL; i++) begin
            if (paddr == `LCC_OFS_CFG_BASE + 12'(i*4)) begin
                rd_mux = cfg_r[i];
                rd_err = 1'b0;
            end
        end
    end

    // One wait state: answer registered in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= acc;
            pslverr_r <= acc & rd_err;
            if (rd_acc) prdata_r <= rd_err ? 32'h0000_0000 : rd_mux;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign cell_q = q_r;
    assign cell_lut_out = lut_r;
    assign cluster_carry_out = carry_out_r;
    assign cluster_cascade_out = casc_out_r;

endmodule
`default_nettype wire

// >>> lcc_params.svh
// Constants for the logic cluster control block: register offsets,
// field positions, reset values and sizes.
// Assumes inclusion by bare name from the package and the cluster module.
`ifndef LCC_PARAMS_SVH
`define LCC_PARAMS_SVH

// Register byte offsets on the APB side
`define LCC_OFS_CTRL 12'h000
`define LCC_OFS_STATUS 12'h004
`define LCC_OFS_CELLS 12'h008
`define LCC_OFS_CFG_BASE 12'h040

// Cluster shape
`define LCC_NUM_CELLS 10
`define LCC_DATA_INPUTS 4
`define LCC_CTL_LIMIT 6

// CTRL fields
`define LCC_CTRL_RST_EN 0
`define LCC_CTRL_EDGE_ONE 1
`define LCC_CTRL_EDGE_TWO 2
`define LCC_CTRL_RESET 32'h0000_0000

// STATUS fields
`define LCC_STAT_OVER 0
`define LCC_STAT_UNK_LSB 4

// CELLS readback fields
`define LCC_CELLS_Q_LSB 0
`define LCC_CELLS_LUT_LSB 16

// Per-cell configuration fields
`define LCC_CFG_MASK_LSB 0
`define LCC_CFG_MODE_LSB 16
`define LCC_CFG_CLKSEL 18
`define LCC_CFG_PACK 19
`define LCC_CFG_CARRY 20
`define LCC_CFG_CASC 21
`define LCC_CFG_ASYNC_LSB 22
`define LCC_CFG_ALINE 24
`define LCC_CFG_ROLE1_LSB 25
`define LCC_CFG_ROLE2_LSB 27
`define LCC_CFG_FBSEL 29
`define LCC_CFG_RESET 32'h0000_0000

`endif

// >>> lcc_pkg.sv
// Types shared by the logic cluster control block.
// Assumes lcc_params.svh is on the include path.
`include "lcc_params.svh"

package lcc_pkg;

    // Cell operating mode
    typedef enum logic [1:0] {
        LCC_MODE_NORMAL = 2'b00,
        LCC_MODE_ARITH = 2'b01,
        LCC_MODE_COUNTER = 2'b10,
        LCC_MODE_RSVD = 2'b11
    } lcc_mode_e;

    // What the selected cluster clear line does to the cell register
    typedef enum logic [1:0] {
        LCC_ASYNC_NONE = 2'b00,
        LCC_ASYNC_CLEAR = 2'b01,
        LCC_ASYNC_PRESET = 2'b10,
        LCC_ASYNC_LOAD = 2'b11
    } lcc_async_e;

    // Use of the first two data inputs
    typedef enum logic [1:0] {
        LCC_ROLE_DATA = 2'b00,
        LCC_ROLE_FEEDBACK = 2'b01,
        LCC_ROLE_COUNT_EN = 2'b10,
        LCC_ROLE_DIR = 2'b11
    } lcc_role_e;

    // Cluster-wide control lines, travelling together through the synchroniser
    typedef struct packed {
        logic clk_one;
        logic clk_two;
        logic ce_one;
        logic ce_two;
        logic clr_one;
        logic clr_two;
        logic sclr;
        logic sload;
        logic rst_n;
        logic carry_in;
        logic casc_in;
    } lcc_ctl_s;

    // Decoded per-cell configuration word
    typedef struct packed {
        logic [1:0] rsvd;
        logic fb_sel;
        lcc_role_e role2;
        lcc_role_e role1;
        logic aline;
        lcc_async_e amode;
        logic use_casc;
        logic use_carry;
        logic pack;
        logic clk_sel;
        lcc_mode_e mode;
        logic [15:0] mask;
    } lcc_cfg_s;

endpackage

// >>> lcc_cluster_monitor.sv
// Concurrent checks on the logic cluster ports: APB handshake and register hold/clear behaviour.
// Assumes binding to lcc_cluster; all controls reach the cells through a two-flop synchroniser.
`timescale 1ns/1ps
`default_nettype none

module lcc_cluster_monitor #(
    parameter int NCELL = 10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Cluster controls
    input wire logic cluster_clock_one,
    input wire logic cluster_clock_two,
    input wire logic cluster_clock_enable_one,
    input wire logic cluster_clock_enable_two,
    input wire logic cluster_clear_one,
    input wire logic cluster_clear_two,
    input wire logic cluster_sync_clear,
    input wire logic chip_reset_n,
    // Cell registers
    input wire logic [NCELL-1:0] cell_q
);
    logic [4:0] ev_r;
    logic [4:0] ev_nxt;
    logic calm;
    logic [3:0] quiet_r;
    logic [3:0] gate_r;
    logic [3:0] sclr_r;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Lines whose movement may legally change a cell register
    assign ev_nxt = {cluster_clock_one, cluster_clock_two, cluster_clear_one,
                     cluster_clear_two, chip_reset_n};
    assign calm = !cluster_clear_one && !cluster_clear_two && chip_reset_n;

    // Cycles since any clock, clear or chip reset line moved; saturates
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_r <= 5'h00;
            quiet_r <= 4'h0;
        end else begin
            ev_r <= ev_nxt;
            quiet_r <= (ev_r != ev_nxt) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
        end
    end

    // Cycles with both enables low, and with sync clear held, while no async control acts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_r <= 4'h0;
            sclr_r <= 4'h0;
        end else begin
            gate_r <= (!cluster_clock_enable_one && !cluster_clock_enable_two && calm) ?
                      gate_r + {3'h0, gate_r != 4'hf} : 4'h0;
            sclr_r <= (cluster_sync_clear && calm) ? sclr_r + {3'h0, sclr_r != 4'hf} : 4'h0;
        end
    end

    AST_READY_NEXT:
        assert property (psel && penable && !pready |=> pready) else $error("pready late");
    AST_READY_PULSE:
        assert property (pready |=> !pready) else $error("pready longer than one cycle");
    AST_ERR_QUAL:
        assert property (pslverr |-> pready) else $error("pslverr without pready");
    AST_READY_CAUSE:
        assert property (pready |-> psel && penable) else $error("pready outside access");
    AST_RESET_QUIET:
        assert property ($rose(presetn) |-> cell_q == '0 && !pready)
            else $error("outputs not clear after reset");
    AST_HOLD_NO_EDGE:
        assert property (quiet_r >= 4'h6 |-> $stable(cell_q)) else $error("capture without edge");
    AST_HOLD_NO_ENABLE:
        assert property (gate_r >= 4'h6 |-> $stable(cell_q)) else $error("capture while gated");
    AST_SCLR_NO_RISE:
        assert property (sclr_r >= 4'h6 |-> (cell_q & ~$past(cell_q)) == '0)
            else $error("register set under sync clear");

    // Main scenarios reached
    COV_ERR: cover property (pslverr);
    COV_CAPTURE: cover property (quiet_r == 4'h6 && cell_q != '0);
    COV_SCLR: cover property (sclr_r == 4'h6);
endmodule

bind lcc_cluster lcc_cluster_monitor #(.NCELL(NCELL)) i_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .cluster_clock_one(cluster_clock_one),
    .cluster_clock_two(cluster_clock_two), .cluster_clock_enable_one(cluster_clock_enable_one),
    .cluster_clock_enable_two(cluster_clock_enable_two), .cluster_clear_one(cluster_clear_one),
    .cluster_clear_two(cluster_clear_two), .cluster_sync_clear(cluster_sync_clear),
    .chip_reset_n(chip_reset_n), .cell_q(cell_q)
);

`default_nettype wire

// >>> lcc_user_model.sv
// User logic driving the cluster-wide control lines.
// Assumes the bench calls its tasks; every line changes just after a pclk edge.
`timescale 1ns/1ps
`default_nettype none

module lcc_user_model
    import lcc_pkg::*;
(
    // Clock
    input wire logic pclk,
    // Controls toward the cluster
    output var lcc_ctl_s ctl
);
    // Quiet start: no clock activity, chip reset released
    initial begin
        ctl = '0;
        ctl.rst_n = 1'b1;
    end

    // Move one clock line; each phase lasts 8 pclk, above the 3 the synchroniser needs
    task automatic level(input logic two, input logic v);
        @(posedge pclk);
        if (two)
            ctl.clk_two <= v;
        else
            ctl.clk_one <= v;
        repeat (7) @(posedge pclk);
    endtask

    // Level controls; callers keep six lines active at most unless overload is the aim
    task automatic lines(input logic e1, e2, c1, c2, sc, sl, rn);
        @(posedge pclk);
        ctl.ce_one <= e1;
        ctl.ce_two <= e2;
        ctl.clr_one <= c1;
        ctl.clr_two <= c2;
        ctl.sclr <= sc;
        ctl.sload <= sl;
        ctl.rst_n <= rn;
        repeat (2) @(posedge pclk);
    endtask
endmodule

`default_nettype wire

// >>> lcc_cluster_tb.sv
// Self-checking bench for the logic cluster: APB register access and cell register control.
// Assumes lcc_user_model drives the control lines; the bench drives APB and cell data.
`timescale 1ns/1ps
`default_nettype none
`include "lcc_params.svh"

module lcc_cluster_tb
    import lcc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [39:0] cell_data = 40'h0;
    logic [9:0] cell_q;
    logic [9:0] cell_lut_out;
    logic chain_carry;
    logic chain_casc;
    lcc_ctl_s ctl;
    int miscompares = 0;
    int num_checks = 0;

    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    lcc_user_model i_user (.pclk(pclk), .ctl(ctl));

    lcc_cluster #(.NCELL(10)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cluster_clock_one(ctl.clk_one), .cluster_clock_two(ctl.clk_two),
        .cluster_clock_enable_one(ctl.ce_one), .cluster_clock_enable_two(ctl.ce_two),
        .cluster_clear_one(ctl.clr_one), .cluster_clear_two(ctl.clr_two),
        .cluster_sync_clear(ctl.sclr), .cluster_sync_load(ctl.sload),
        .chip_reset_n(ctl.rst_n), .cluster_carry_in(ctl.carry_in),
        .cluster_cascade_in(ctl.casc_in), .cell_data(cell_data), .cell_q(cell_q),
        .cell_lut_out(cell_lut_out), .cluster_carry_out(chain_carry),
        .cluster_cascade_out(chain_casc)
    );

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic q_chk(input logic [9:0] exp);
        chk({22'h0, cell_q}, {22'h0, exp});
    endtask

    // One APB transfer; the wait for pready is bounded
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) begin
            miscompares++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, experr});
    endtask

    // Even cells on line one with clear line one, odd on line two with clear line two
    task automatic cfg_all(input lcc_async_e ae, input lcc_async_e ao);
        lcc_cfg_s c;
        for (int i = 0; i < 10; i++) begin
            c = '0;
            c.mask = 16'haaaa;
            c.clk_sel = i[0];
            c.aline = i[0];
            c.amode = i[0] ? ao : ae;
            wr(`LCC_OFS_CFG_BASE + 12'(4 * i), c);
        end
    endtask

    // Rising then falling edge on both lines
    task automatic cycle_both;
        i_user.level(1'b0, 1'b1);
        i_user.level(1'b0, 1'b0);
        i_user.level(1'b1, 1'b1);
        i_user.level(1'b1, 1'b0);
    endtask

    task automatic t_regs;
        rd_chk(`LCC_OFS_CTRL, `LCC_CTRL_RESET, 1'b0);
        wr(12'hffc, 32'hffff_ffff);
        rd_chk(12'hffc, 32'h0, 1'b1);
        wr(`LCC_OFS_CTRL, 32'h4);
        rd_chk(`LCC_OFS_CTRL, 32'h4, 1'b0);
        $display("test regs done");
    endtask

    task automatic t_capture;
        cfg_all(LCC_ASYNC_NONE, LCC_ASYNC_NONE);
        cell_data <= {10{4'h1}};
        i_user.lines(1, 0, 0, 0, 0, 0, 1);
        i_user.level(1'b0, 1'b1);
        q_chk(10'h155);
        chk({30'h0, chain_carry, chain_casc}, 32'h1);
        i_user.level(1'b1, 1'b1);
        i_user.level(1'b1, 1'b0);
        q_chk(10'h155);
        i_user.lines(0, 1, 0, 0, 0, 0, 1);
        i_user.level(1'b1, 1'b1);
        q_chk(10'h155);
        i_user.level(1'b1, 1'b0);
        q_chk(10'h3ff);
        cell_data <= 40'h0;
        i_user.level(1'b0, 1'b0);
        i_user.level(1'b0, 1'b1);
        q_chk(10'h3ff);
        i_user.level(1'b0, 1'b0);
        $display("test capture done");
    endtask

    task automatic t_sync;
        cell_data <= {10{4'h1}};
        i_user.lines(1, 1, 0, 0, 0, 1, 1);
        cycle_both();
        q_chk(10'h000);
        cell_data <= {10{4'h8}};
        cycle_both();
        q_chk(10'h3ff);
        i_user.lines(1, 1, 0, 0, 1, 1, 1);
        cycle_both();
        q_chk(10'h000);
        $display("test sync done");
    endtask

    task automatic t_async;
        cfg_all(LCC_ASYNC_CLEAR, LCC_ASYNC_PRESET);
        i_user.lines(1, 1, 0, 1, 0, 0, 1);
        repeat (6) @(posedge pclk);
        q_chk(10'h2aa);
        i_user.lines(1, 1, 0, 0, 0, 1, 1);
        cycle_both();
        i_user.lines(1, 1, 1, 0, 0, 1, 1);
        repeat (6) @(posedge pclk);
        q_chk(10'h2aa);
        i_user.lines(1, 1, 0, 0, 0, 1, 1);
        cycle_both();
        q_chk(10'h3ff);
        wr(`LCC_OFS_CTRL, 32'h5);
        i_user.lines(1, 1, 0, 0, 0, 1, 0);
        cycle_both();
        q_chk(10'h2aa);
        i_user.lines(0, 0, 0, 0, 0, 0, 1);
        $display("test async done");
    endtask

    task automatic t_arith;
        lcc_cfg_s c;
        c = '0;
        c.mode = LCC_MODE_ARITH;
        c.mask = 16'h0066;
        wr(`LCC_OFS_CFG_BASE, c);
        cell_data <= 40'h1;
        i_user.lines(1, 0, 0, 0, 0, 0, 1);
        repeat (6) @(posedge pclk);
        chk({31'h0, cell_lut_out[0]}, 32'h1);
        i_user.level(1'b0, 1'b1);
        chk({31'h0, cell_q[0]}, 32'h1);
        cell_data <= 40'h3;
        i_user.level(1'b0, 1'b0);
        chk({31'h0, cell_lut_out[0]}, 32'h0);
        $display("test arith done");
    endtask

    task automatic t_overload;
        i_user.lines(1, 1, 1, 1, 1, 1, 1);
        rd_chk(`LCC_OFS_STATUS, 32'h0, 1'b0);
        i_user.level(1'b0, 1'b1);
        i_user.level(1'b0, 1'b0);
        i_user.lines(0, 0, 0, 0, 0, 0, 1);
        rd_chk(`LCC_OFS_STATUS, 32'h1, 1'b0);
        wr(`LCC_OFS_STATUS, 32'h1);
        rd_chk(`LCC_OFS_STATUS, 32'h0, 1'b0);
        $display("test overload done");
    endtask

    // Main sequence after 16 cycles of reset
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_capture();
        t_sync();
        t_async();
        t_arith();
        t_overload();
        final_report();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        final_report();
    end
endmodule

`default_nettype wire
